/* dv/sar_adc_monitor.sv */
`timescale 1ns/1ps
module sar_adc_monitor (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic DIN,
   input wire logic DOUT,
   input wire logic DOUT_OE,
   input wire logic STANDBY,
   input wire logic LINK_ARMED
);
   logic started_reg;
   logic [4:0] cnt_reg;
   // rises after start; cleared by select high just like the link
   always_ff @(posedge SCLK or posedge CS_N or negedge RST_N) begin
      if (!RST_N || CS_N) begin
         started_reg <= 1'b0;
         cnt_reg <= 5'h00;
      end else if (!started_reg) begin
         started_reg <= DIN && LINK_ARMED;
      end else if (cnt_reg != 5'h1f) begin
         cnt_reg <= cnt_reg + 5'h01;
      end
   end
   a_oe_cs_high: assert property (@(posedge CORE_CLK) disable iff (!RST_N) CS_N |-> !DOUT_OE)
      else $error("output enabled with select high");
   a_standby_up: assert property (@(posedge CORE_CLK) disable iff (!RST_N) CS_N [*5] |-> STANDBY)
      else $error("standby missing");
   a_standby_down: assert property (@(posedge CORE_CLK) disable iff (!RST_N) !CS_N [*5] |-> !STANDBY)
      else $error("standby while selected");
   a_dout_held: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      SCLK && $past(SCLK) && !CS_N && !$past(CS_N) |-> $stable(DOUT) && $stable(DOUT_OE))
      else $error("output moved while clock high");
   a_null_low: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      $rose(DOUT_OE) |-> !DOUT && !SCLK)
      else $error("null bit not low");
   a_no_arm: assert property (@(posedge CORE_CLK) disable iff (!RST_N) !LINK_ARMED |-> !DOUT_OE)
      else $error("output before arming");
   a_armed_sticky: assert property (@(posedge CORE_CLK) disable iff (!RST_N) LINK_ARMED |=> LINK_ARMED)
      else $error("arming lost");
   a_oe_window: assert property (@(posedge SCLK) disable iff (!RST_N || CS_N)
      1'b1 |-> DOUT_OE == (started_reg && cnt_reg >= 5'h05))
      else $error("output enable in wrong slot");
   a_tail_zeros: assert property (@(posedge SCLK) disable iff (!RST_N || CS_N)
      cnt_reg >= 5'h19 |-> !DOUT)
      else $error("tail not zero");
   c_full_frame: cover property (@(posedge SCLK) cnt_reg == 5'h1c);
   c_abort: cover property (@(posedge CORE_CLK) $fell(DOUT_OE));
   c_standby: cover property (@(posedge CORE_CLK) $rose(STANDBY));
endmodule
bind sar_adc_serial sar_adc_monitor mon_u (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .SCLK(SCLK),
   .CS_N(CS_N), .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .STANDBY(STANDBY),
   .LINK_ARMED(LINK_ARMED));

/* dv/spi_ctl_model.sv */
`timescale 1ns/1ps
module spi_ctl_model (
   input wire logic core_clk,
   input wire logic dout,
   input wire logic dout_oe,
   output logic sclk,
   output logic cs_n,
   output logic din
);
   logic [23:0] rx;
   int oe_n;
   // clock idles low; select low from power-up on purpose
   initial begin
      sclk = 1'b0;
      cs_n = 1'b0;
      din = 1'b0;
   end
   task automatic frame(input int lead, input logic [3:0] cmd, input int n);
      logic [4:0] tx;
      tx = {1'b1, cmd};
      rx = '0;
      oe_n = 0;
      @(posedge core_clk) cs_n <= 1'b0;
      // off the core grid, so no link edge ever meets a core edge
      #7.3;
      // whole readout far inside the hold limit
      for (int k = 0; k < n; k++) begin
         // filler bits after the select bits are don't care
         din = (k < lead) ? 1'b0 : (k < lead + 5) ? tx[4 - (k - lead)] : k[0];
         #24 sclk = 1'b1;
         // a released output reads as the inverse of its last value
         rx = {rx[22:0], dout_oe ? dout : ~dout};
         oe_n += dout_oe;
         #24 sclk = 1'b0;
      end
      @(posedge core_clk) cs_n <= 1'b1;
      din = ~din;
      #100;
   endtask
endmodule

/* dv/test_sar_adc_serial.sv */
`timescale 1ns/1ps
module test_sar_adc_serial;
   import sar_adc_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic chan8 = 1'b1;
   logic sclk, cs_n, din, dout, dout_oe, standby, link_armed;
   logic [AIN_W-1:0] ain [8] = '{13'h0ffc, 13'h0005, 13'h1fff, 13'h0a55,
      13'h0404, 13'h0800, 13'h0003, 13'h1000};
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;
   always #2.5 core_clk = ~core_clk;
   sar_adc_serial dut_u (.CORE_CLK(core_clk), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n),
      .DIN(din), .DOUT(dout), .DOUT_OE(dout_oe), .CHANNELS_8(chan8),
      .ANALOG_IN_0(ain[0]), .ANALOG_IN_1(ain[1]), .ANALOG_IN_2(ain[2]), .ANALOG_IN_3(ain[3]),
      .ANALOG_IN_4(ain[4]), .ANALOG_IN_5(ain[5]), .ANALOG_IN_6(ain[6]), .ANALOG_IN_7(ain[7]),
      .STANDBY(standby), .LINK_ARMED(link_armed));
   spi_ctl_model ctl_u (.core_clk(core_clk), .dout(dout), .dout_oe(dout_oe), .sclk(sclk),
      .cs_n(cs_n), .din(din));
   function automatic logic [9:0] exp_code(logic m, logic [2:0] s);
      logic [2:0] i;
      logic [13:0] d;
      i = {s[2] & chan8, s[1:0]};
      d = m ? {1'b0, ain[i]} : {1'b0, ain[i]} - {1'b0, ain[i ^ 3'h1]};
      if (!m && ain[i] <= ain[i ^ 3'h1]) return 10'h000;
      return (d >= 14'h1000) ? 10'h3ff : d[11:2];
   endfunction
   // null, msb first, lsb first without b0, then zeros
   function automatic logic [23:0] exp_stream(logic [9:0] c);
      logic [23:0] s;
      s = '0;
      s[22:13] = c;
      for (int b = 1; b < 10; b++) s[13 - b] = c[b];
      return s;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         complete_run();
      end
   end
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      ctl_u.frame(3, 4'hf, 33);
      check(ctl_u.oe_n, 0);
      check(link_armed, 1);
      check(standby, 1);
      for (int c = 1; c >= 0; c--) begin
         @(posedge core_clk);
         chan8 <= c[0];
         foreach (ain[i]) ain[i] <= ~ain[i];
         for (int k = 0; k < 16; k++) begin
            ctl_u.frame(k % 4, k[3:0], k % 4 + 30);
            check(ctl_u.rx, exp_stream(exp_code(k[3], k[2:0])));
            check(ctl_u.oe_n, 24);
         end
      end
      ctl_u.frame(1, 4'h9, 13);
      check(dout_oe, 0);
      check(ctl_u.oe_n, 6);
      ctl_u.frame(0, 4'h9, 30);
      check(ctl_u.rx, exp_stream(exp_code(1'b1, 3'h1)));
      complete_run();
   end
endmodule

/* rtl/sar_adc_pkg.sv */
package sar_adc_pkg;
   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int CODE_W = 10;
   localparam int AIN_W = 13;
   localparam int CNT_W = 5;
   localparam int NUM_CH = 8;

   // ------------------------------------------------------------
   // rising-edge counts after the start bit
   // ------------------------------------------------------------
   localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
   localparam logic [CNT_W-1:0] CNT_MODE = 5'h01;
   localparam logic [CNT_W-1:0] CNT_SEL2 = 5'h02;
   localparam logic [CNT_W-1:0] CNT_SEL1 = 5'h03;
   localparam logic [CNT_W-1:0] CNT_SEL0 = 5'h04;
   localparam logic [CNT_W-1:0] CNT_NULL = 5'h05;
   localparam logic [CNT_W-1:0] CNT_MSB_FIRST = 5'h06;
   localparam logic [CNT_W-1:0] CNT_MSB_LAST = 5'h0f;
   localparam logic [CNT_W-1:0] CNT_LSB_FIRST = 5'h10;
   localparam logic [CNT_W-1:0] CNT_LSB_LAST = 5'h18;
   localparam logic [CNT_W-1:0] CNT_ZEROS = 5'h19;

   // ------------------------------------------------------------
   // codes and reset values
   // ------------------------------------------------------------
   localparam logic [CODE_W-1:0] CODE_ZERO = 10'h000;
   localparam logic [CODE_W-1:0] CODE_FULL = 10'h3ff;
   localparam logic [AIN_W-1:0] AIN_RESET = 13'h0000;
   // input units: full scale reference equals this many units
   localparam logic [AIN_W-1:0] VREF_UNITS = 13'h1000;
   localparam int LSB_SHIFT = 2;
endpackage

/* rtl/sar_adc_serial.sv */
`timescale 1ns/1ps
module sar_adc_serial (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic DIN,
   output logic DOUT,
   output logic DOUT_OE,
   input wire logic CHANNELS_8,
   input wire logic [sar_adc_pkg::AIN_W-1:0] ANALOG_IN_0,
   input wire logic [sar_adc_pkg::AIN_W-1:0] ANALOG_IN_1,
   input wire logic [sar_adc_pkg::AIN_W-1:0] ANALOG_IN_2,
   input wire logic [sar_adc_pkg::AIN_W-1:0] ANALOG_IN_3,
   input wire logic [sar_adc_pkg::AIN_W-1:0] ANALOG_IN_4,
   input wire logic [sar_adc_pkg::AIN_W-1:0] ANALOG_IN_5,
   input wire logic [sar_adc_pkg::AIN_W-1:0] ANALOG_IN_6,
   input wire logic [sar_adc_pkg::AIN_W-1:0] ANALOG_IN_7,
   output logic STANDBY,
   output logic LINK_ARMED
);
   import sar_adc_pkg::*;

   // ------------------------------------------------------------
   // state types
   // ------------------------------------------------------------
   typedef struct packed {
      logic cs_meta;
      logic cs_sync;
      logic armed;
      logic standby;
   } core_t;

   typedef struct packed {
      logic started;
      logic [CNT_W-1:0] cnt;
      logic mode;
      logic [2:0] sel;
      logic [NUM_CH-1:0][AIN_W-1:0] ain_meta;
      logic [NUM_CH-1:0][AIN_W-1:0] ain_sync;
      logic ch8_meta;
      logic ch8_sync;
   } rise_t;

   typedef struct packed {
      logic [CODE_W-1:0] result;
      logic dout;
      logic oe;
   } fall_t;

   // output slot of the current link cycle
   typedef enum logic [2:0] {
      PH_WAIT,
      PH_CMD,
      PH_NULL,
      PH_MSB,
      PH_LSB,
      PH_ZERO
   } phase_t;

   core_t core_reg;
   core_t core_next;
   rise_t rise_reg;
   rise_t rise_next;
   fall_t fall_reg;
   fall_t fall_next;

   // slot of the link cycle, decoded from the rising-edge count
   phase_t phase;
   logic link_rst_n;
   logic [NUM_CH-1:0][AIN_W-1:0] ain_pins;
   logic [2:0] sel_eff;
   logic [2:0] pos_idx;
   logic [2:0] neg_idx;
   logic [AIN_W-1:0] pos_val;
   logic [AIN_W-1:0] neg_val;
   logic [CODE_W-1:0] code_w;
   logic [CNT_W-1:0] edge_num;
   logic [CNT_W-1:0] bit_idx;

   assign ain_pins = {ANALOG_IN_7, ANALOG_IN_6, ANALOG_IN_5, ANALOG_IN_4,
                      ANALOG_IN_3, ANALOG_IN_2, ANALOG_IN_1, ANALOG_IN_0};

   // ------------------------------------------------------------
   // core domain: chip select watch and arming
   // ------------------------------------------------------------
   always_comb begin
      core_next = core_reg;
      core_next.cs_meta = CS_N;
      core_next.cs_sync = core_reg.cs_meta;
      // arm only after select seen high
      if (core_reg.cs_sync) begin
         core_next.armed = 1'b1;
      end
      // standby lags select by three core cycles
      // standby while deselected
      core_next.standby = core_reg.cs_sync;
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         core_reg <= '{cs_meta: 1'b0, cs_sync: 1'b0, armed: 1'b0, standby: 1'b0};
      end else begin
         core_reg <= core_next;
      end
   end

   assign STANDBY = core_reg.standby;
   assign LINK_ARMED = core_reg.armed;

   // ------------------------------------------------------------
   // link reset
   // ------------------------------------------------------------
   // select high holds the whole link side in reset; sclk may be still
   // outside frames so nothing there may need an edge to end a frame.
   // armed is set long before select can fall, so its release is clean.
   // the arming flag only gates this reset and never enters sclk logic
   // select low releases the link
   assign link_rst_n = RST_N & ~CS_N & core_reg.armed;

   // ------------------------------------------------------------
   // link rising edges: command capture
   // ------------------------------------------------------------
   assign edge_num = rise_reg.cnt + 5'h01;

   always_comb begin
      rise_next = rise_reg;
      // strap and analog levels pass two stages before use
      // limitation: the strap must not move while a frame runs
      rise_next.ch8_meta = CHANNELS_8;
      rise_next.ch8_sync = rise_reg.ch8_meta;
      rise_next.ain_meta = ain_pins;
      rise_next.ain_sync = rise_reg.ain_meta;
      if (!rise_reg.started) begin
         // leading zeros ignored, first high is start
         if (DIN) begin
            rise_next.started = 1'b1;
            rise_next.cnt = CNT_RESET;
         end
      end else begin
         // counter saturates in the zeros phase
         if (rise_reg.cnt != CNT_ZEROS) begin
            rise_next.cnt = edge_num;
         end
         case (edge_num)
            CNT_MODE: rise_next.mode = DIN;
            CNT_SEL2: rise_next.sel[2] = DIN;
            CNT_SEL1: rise_next.sel[1] = DIN;
            CNT_SEL0: rise_next.sel[0] = DIN;
            default: begin
               rise_next.mode = rise_reg.mode;
            end
         endcase
      end
   end

   always_ff @(posedge SCLK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rise_reg.started <= 1'b0;
         rise_reg.cnt <= CNT_RESET;
         rise_reg.mode <= 1'b0;
         rise_reg.sel <= 3'h0;
         rise_reg.ch8_meta <= 1'b0;
         rise_reg.ch8_sync <= 1'b0;
         rise_reg.ain_meta <= {NUM_CH{AIN_RESET}};
         rise_reg.ain_sync <= {NUM_CH{AIN_RESET}};
      end else begin
         rise_reg <= rise_next;
      end
   end

   // ------------------------------------------------------------
   // channel selection
   // ------------------------------------------------------------
   always_comb begin
      // small variant ignores the top select bit
      sel_eff = {rise_reg.sel[2] & rise_reg.ch8_sync, rise_reg.sel[1:0]};
      pos_idx = sel_eff;
      neg_idx = sel_eff;
      // one entry per configuration, mode bit on top
      case ({rise_reg.mode, sel_eff})
         // single-ended: the select value is the channel
         4'h8: pos_idx = 3'h0;
         4'h9: pos_idx = 3'h1;
         4'ha: pos_idx = 3'h2;
         4'hb: pos_idx = 3'h3;
         4'hc: pos_idx = 3'h4;
         4'hd: pos_idx = 3'h5;
         4'he: pos_idx = 3'h6;
         4'hf: pos_idx = 3'h7;
         // differential: even/odd pair, low bit makes the odd member positive
         4'h0: begin
            pos_idx = 3'h0;
            neg_idx = 3'h1;
         end
         4'h1: begin
            pos_idx = 3'h1;
            neg_idx = 3'h0;
         end
         4'h2: begin
            pos_idx = 3'h2;
            neg_idx = 3'h3;
         end
         4'h3: begin
            pos_idx = 3'h3;
            neg_idx = 3'h2;
         end
         4'h4: begin
            pos_idx = 3'h4;
            neg_idx = 3'h5;
         end
         4'h5: begin
            pos_idx = 3'h5;
            neg_idx = 3'h4;
         end
         4'h6: begin
            pos_idx = 3'h6;
            neg_idx = 3'h7;
         end
         4'h7: begin
            pos_idx = 3'h7;
            neg_idx = 3'h6;
         end
         default: begin
            pos_idx = sel_eff;
            neg_idx = sel_eff;
         end
      endcase
      pos_val = rise_reg.ain_sync[pos_idx];
      // mode one single-ended against ground, zero differential
      if (rise_reg.mode) begin
         neg_val = AIN_RESET;
      end else begin
         neg_val = rise_reg.ain_sync[neg_idx];
      end
   end

   // conversion is combinational; its value is taken at the null slot
   sar_code_calc u_code (
      .pos_in(pos_val),
      .neg_in(neg_val),
      .code(code_w)
   );

   // ------------------------------------------------------------
   // output slot decode
   // ------------------------------------------------------------
   // read on falling edges, half a clock after the count has moved
   always_comb begin
      phase = PH_WAIT;
      if (rise_reg.started) begin
         if (rise_reg.cnt < CNT_NULL) begin
            phase = PH_CMD;
         end else if (rise_reg.cnt == CNT_NULL) begin
            phase = PH_NULL;
         end else if (rise_reg.cnt >= CNT_MSB_FIRST && rise_reg.cnt <= CNT_MSB_LAST) begin
            phase = PH_MSB;
         end else if (rise_reg.cnt >= CNT_LSB_FIRST && rise_reg.cnt <= CNT_LSB_LAST) begin
            phase = PH_LSB;
         end else if (rise_reg.cnt == CNT_ZEROS) begin
            phase = PH_ZERO;
         end
      end
   end

   // ------------------------------------------------------------
   // link falling edges: serial output
   // ------------------------------------------------------------
   always_comb begin
      fall_next = fall_reg;
      bit_idx = CNT_RESET;
      case (phase)
         PH_NULL: begin
            fall_next.result = code_w;
            fall_next.dout = 1'b0;
            fall_next.oe = 1'b1;
         end
         PH_MSB: begin
            bit_idx = CNT_MSB_LAST - rise_reg.cnt;
            fall_next.dout = fall_reg.result[bit_idx[3:0]];
         end
         PH_LSB: begin
            // lsb first, bit 0 not repeated
            bit_idx = rise_reg.cnt - CNT_MSB_LAST;
            fall_next.dout = fall_reg.result[bit_idx[3:0]];
         end
         PH_ZERO: begin
            fall_next.dout = 1'b0;
         end
         default: begin
            // still released during the command slots
            fall_next.oe = fall_reg.oe;
         end
      endcase
   end

   // output moves on falling edges and clears at once when select goes high
   always_ff @(negedge SCLK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         fall_reg <= '{result: CODE_ZERO, dout: 1'b0, oe: 1'b0};
      end else begin
         fall_reg <= fall_next;
      end
   end

   assign DOUT = fall_reg.dout;
   assign DOUT_OE = fall_reg.oe;
endmodule

/* rtl/sar_code_calc.sv */
`timescale 1ns/1ps
module sar_code_calc (
   input wire logic [sar_adc_pkg::AIN_W-1:0] pos_in,
   input wire logic [sar_adc_pkg::AIN_W-1:0] neg_in,
   output logic [sar_adc_pkg::CODE_W-1:0] code
);
   import sar_adc_pkg::*;

   logic [AIN_W-1:0] diff;

   always_comb begin
      diff = pos_in - neg_in;
      if (pos_in <= neg_in) begin
         code = CODE_ZERO;
      end else if (diff >= VREF_UNITS) begin
         code = CODE_FULL;
      end else begin
         code = diff[LSB_SHIFT +: CODE_W];
      end
   end
endmodule
